// ### common/ppc_cfg.svh
// Constants of the port pin configuration and comparator control block.
// Assumes a Wishbone slave with word-aligned registers and a 125 MHz core clock.
// Overview of operation
// RULE_01 - Direction bit 0 drives the pin as output; 1 leaves it high impedance.
// RULE_02 - Pull-up bits 6..0 map to pins; 0 enables the pull-up, 1 disables.
// RULE_03 - Bit 7 of pull-up, pull-down, open-drain reads zero; others read and write.
// RULE_04 - Pull-down bits 6..0 map to pins; 0 enables the pull-down, 1 disables.
// RULE_05 - Open-drain bits 6..0 map to pins; 0 open-drain, 1 push-pull.
// RULE_06 - Comparator bit 7 is active-low reference enable, default 0; minus pin stays I/O.
// RULE_07 - Ratio field bits 6..3 gives code/15 of supply; all ones is default.
// RULE_08 - Comparator bit 2 shows live comparator output and ignores writes.
// RULE_09 - Select 00 leaves comparator off; 01 runs it; shared pin stays I/O.
// RULE_10 - Select 10 drives comparator output on shared pin; 11 enables nothing.
// RULE_11 - Shared pin priority: timer input, comparator output, analog input five, I/O.
// RULE_12 - Timer source bit 5: 0 instruction clock, 1 timer pin transitions.
// RULE_13 - Software keeps timer source 0 while the shared pin is plain I/O.
// RULE_14 - Timer edge bit 4: 0 counts rising edges, 1 counts falling edges.
// RULE_15 - Timer pin is synchronised; an edge from two samples gives one count.
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
// ----------------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------------
`define PPC_IDX_TIMER 3'h0
`define PPC_IDX_DIR 3'h1
`define PPC_IDX_PU 3'h2
`define PPC_IDX_PD 3'h3
`define PPC_IDX_OD 3'h4
`define PPC_IDX_CMP 3'h5
`define PPC_IDX_COUNT 3'h6
`define PPC_IDX_DATA 3'h7
// ----------------------------------------------------------------------
// Field positions, masks and reset values
// ----------------------------------------------------------------------
`define PPC_BIT_TS 5
`define PPC_BIT_TE 4
`define PPC_BIT_INTERNAL_REF_ENABLE_N 7
`define PPC_BIT_COMPARATOR_RESULT 2
`define PPC_SHARED_PIN 5
`define PPC_MINUS_PIN 4
`define PPC_TIMER_IRQ_CONFIG_WMASK 8'hbf
`define PPC_CMP_WMASK 8'hfb
`define PPC_RST_TIMER_IRQ_CONFIG 8'h00
`define PPC_RST_PIN7 7'h7f
`define PPC_RST_DOUT 7'h00
`define PPC_RST_CMP 8'h78
`define PPC_COS_OFF 2'h0
`define PPC_COS_RUN 2'h1
`define PPC_COS_PIN 2'h2
`define PPC_COS_NONE 2'h3
`define PPC_COS_HI 1
`define PPC_COS_LO 0
`define PPC_RATIO_HI 6
`define PPC_RATIO_LO 3
`define PPC_ADR_HI 4
`define PPC_ADR_LO 2
`endif

// ### common/ppc_pkg.sv
// Types of the port pin configuration and comparator control block.
// Assumes ppc_cfg.svh supplies every numeric constant.
package ppc_pkg;
  typedef enum logic [1:0] {PPC_FN_IO, PPC_FN_ANALOG, PPC_FN_CMP, PPC_FN_TIMER} ppc_fn_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] timer_irq_config;
    logic [6:0] dir;
    logic [6:0] pu;
    logic [6:0] pd;
    logic [6:0] od;
    logic [6:0] dout;
    logic [7:0] cmp;
    logic [7:0] tcnt;
    logic [6:0] s1;
    logic [6:0] s2;
    logic t5prev;
    logic c1;
    logic c2;
    logic [6:0] pout;
    logic [6:0] poe;
    ppc_fn_t fn;
  } ppc_state_t;
endpackage

// ### rtl/ppc_top.sv
// Port pin configuration, shared pin mux, timer input counter and comparator control.
// Assumes pads resolve the pin from pin_out_o and pin_oe_o, and the comparator is analog.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`include "ppc_cfg.svh"
module ppc_top
  import ppc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port pins
  input wire logic [6:0] pin_in_i,
  output logic [6:0] pin_out_o,
  output logic [6:0] pin_oe_o,
  output logic [6:0] pullup_en_o,
  output logic [6:0] pulldown_en_o,
  // Shared pin and timer
  input wire logic analog_input_five_i,
  input wire logic instr_tick_i,
  output ppc_fn_t shared_fn_o,
  output logic [7:0] timer_count_o,
  // Comparator
  input wire logic comparator_result_i,
  output logic comparator_on_o,
  output logic internal_ref_on_o,
  output logic [3:0] reference_ratio_o,
  output logic comparator_minus_input_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ppc_state_t st_reg;
  ppc_state_t st_next;
  logic [2:0] idx;
  logic wr;
  logic rd_edge;
  logic fl_edge;
  logic cmp_run;
  logic [6:0] ctl_oe;
  logic [6:0] ctl_out;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] dat, input logic [7:0] msk);
    merge = (old & ~msk) | (dat & msk);
  endfunction

  // Select 11 is reserved, so only the two run codes may switch the comparator on.
  function automatic logic cmp_active(input logic [1:0] cos);
    cmp_active = (cos == `PPC_COS_RUN) || (cos == `PPC_COS_PIN);
  endfunction

  assign idx = wb_adr_i[`PPC_ADR_HI:`PPC_ADR_LO];
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !st_reg.ack;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // RULE_15 two-stage sync
    st_next.s1 = pin_in_i;
    st_next.s2 = st_reg.s1;
    st_next.t5prev = st_reg.s2[`PPC_SHARED_PIN];
    st_next.c1 = comparator_result_i;
    st_next.c2 = st_reg.c1;
    // RULE_15 edge from samples
    rd_edge = st_reg.s2[`PPC_SHARED_PIN] && !st_reg.t5prev;
    fl_edge = !st_reg.s2[`PPC_SHARED_PIN] && st_reg.t5prev;
    // RULE_12 timer source select
    if (st_reg.timer_irq_config[`PPC_BIT_TS]) begin
      // RULE_14 edge polarity select
      if (st_reg.timer_irq_config[`PPC_BIT_TE] ? fl_edge : rd_edge) begin
        st_next.tcnt = st_reg.tcnt + 8'h01;
      end
    end else if (instr_tick_i) begin
      st_next.tcnt = st_reg.tcnt + 8'h01;
    end
    st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
    st_next.rdat = 32'h0000_0000;
    // RULE_03 bit seven reads zero
    case (idx)
      `PPC_IDX_TIMER: st_next.rdat[7:0] = st_reg.timer_irq_config & `PPC_TIMER_IRQ_CONFIG_WMASK;
      `PPC_IDX_DIR: st_next.rdat[6:0] = st_reg.dir;
      `PPC_IDX_PU: st_next.rdat[6:0] = st_reg.pu;
      `PPC_IDX_PD: st_next.rdat[6:0] = st_reg.pd;
      `PPC_IDX_OD: st_next.rdat[6:0] = st_reg.od;
      `PPC_IDX_CMP: begin
        // RULE_08 live comparator result
        st_next.rdat[7:0] = st_reg.cmp & `PPC_CMP_WMASK;
        st_next.rdat[`PPC_BIT_COMPARATOR_RESULT] = st_reg.c2;
      end
      `PPC_IDX_COUNT: st_next.rdat[7:0] = st_reg.tcnt;
      `PPC_IDX_DATA: st_next.rdat[6:0] = st_reg.s2;
      default: st_next.rdat = 32'h0000_0000;
    endcase
    // A write in the same cycle as an increment wins, so software can preset the count.
    if (wr) begin
      case (idx)
        `PPC_IDX_TIMER: st_next.timer_irq_config = merge(st_reg.timer_irq_config, wb_dat_i[7:0], `PPC_TIMER_IRQ_CONFIG_WMASK);
        `PPC_IDX_DIR: st_next.dir = wb_dat_i[6:0];
        `PPC_IDX_PU: st_next.pu = wb_dat_i[6:0];
        `PPC_IDX_PD: st_next.pd = wb_dat_i[6:0];
        `PPC_IDX_OD: st_next.od = wb_dat_i[6:0];
        // RULE_08 result bit ignores writes
        `PPC_IDX_CMP: st_next.cmp = merge(st_reg.cmp, wb_dat_i[7:0], `PPC_CMP_WMASK);
        `PPC_IDX_COUNT: st_next.tcnt = wb_dat_i[7:0];
        `PPC_IDX_DATA: st_next.dout = wb_dat_i[6:0];
        default: st_next.dout = st_reg.dout;
      endcase
    end
    // RULE_09 comparator runs on 01 or 10
    cmp_run = cmp_active(st_reg.cmp[`PPC_COS_HI:`PPC_COS_LO]);
    // RULE_11 shared pin priority
    if (st_reg.timer_irq_config[`PPC_BIT_TS]) begin
      st_next.fn = PPC_FN_TIMER;
    end else if (st_reg.cmp[`PPC_COS_HI:`PPC_COS_LO] == `PPC_COS_PIN) begin
      st_next.fn = PPC_FN_CMP;
    end else if (analog_input_five_i) begin
      st_next.fn = PPC_FN_ANALOG;
    end else begin
      st_next.fn = PPC_FN_IO;
    end
    for (int i = 0; i < 7; i++) begin
      // RULE_01 direction and RULE_05 open drain
      ctl_oe[i] = !st_reg.dir[i] && (st_reg.od[i] || !st_reg.dout[i]);
      ctl_out[i] = st_reg.od[i] && st_reg.dout[i];
    end
    // RULE_06 minus input analog only with reference disabled
    if (st_reg.cmp[`PPC_BIT_INTERNAL_REF_ENABLE_N] && cmp_run) begin
      ctl_oe[`PPC_MINUS_PIN] = 1'b0;
    end
    case (st_next.fn)
      PPC_FN_TIMER, PPC_FN_ANALOG: ctl_oe[`PPC_SHARED_PIN] = 1'b0;
      PPC_FN_CMP: begin
        // RULE_10 comparator drives shared pin
        ctl_oe[`PPC_SHARED_PIN] = 1'b1;
        ctl_out[`PPC_SHARED_PIN] = st_reg.c2;
      end
      default: ctl_out[`PPC_SHARED_PIN] = ctl_out[`PPC_SHARED_PIN];
    endcase
    st_next.poe = ctl_oe;
    st_next.pout = ctl_out;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.timer_irq_config <= `PPC_RST_TIMER_IRQ_CONFIG;
      st_reg.dir <= `PPC_RST_PIN7;
      st_reg.pu <= `PPC_RST_PIN7;
      st_reg.pd <= `PPC_RST_PIN7;
      st_reg.od <= `PPC_RST_PIN7;
      st_reg.dout <= `PPC_RST_DOUT;
      // RULE_07 ratio default all ones
      st_reg.cmp <= `PPC_RST_CMP;
      st_reg.fn <= PPC_FN_IO;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdat;
  assign pin_out_o = st_reg.pout;
  assign pin_oe_o = st_reg.poe;
  // RULE_02 pull-up active low
  assign pullup_en_o = ~st_reg.pu;
  // RULE_04 pull-down active low
  assign pulldown_en_o = ~st_reg.pd;
  assign shared_fn_o = st_reg.fn;
  assign timer_count_o = st_reg.tcnt;
  // RULE_10 select 11 enables nothing
  assign comparator_on_o = cmp_active(st_reg.cmp[`PPC_COS_HI:`PPC_COS_LO]);
  assign internal_ref_on_o = comparator_on_o && !st_reg.cmp[`PPC_BIT_INTERNAL_REF_ENABLE_N];
  // RULE_07 ratio field
  assign reference_ratio_o = st_reg.cmp[`PPC_RATIO_HI:`PPC_RATIO_LO];
  assign comparator_minus_input_o = comparator_on_o && st_reg.cmp[`PPC_BIT_INTERNAL_REF_ENABLE_N];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_dir_input;
    st_reg.dir[0] |=> !pin_oe_o[0];
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("input pin driven"); // RULE_01

  property p_pullup;
    pullup_en_o == ~wb_dat_o[6:0] || !$past(wb_cyc_i && idx == `PPC_IDX_PU && !wb_we_i && !st_reg.ack) || $past(wr);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up mismatch"); // RULE_02

  property p_bit7_zero;
    wb_ack_o && $past(idx == `PPC_IDX_PU || idx == `PPC_IDX_PD || idx == `PPC_IDX_OD) |-> !wb_dat_o[7];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("bit 7 not zero"); // RULE_03

  property p_pd_write;
    wr && idx == `PPC_IDX_PD |=> pulldown_en_o == ~$past(wb_dat_i[6:0]);
  endproperty
  a_pd_write: assert property (p_pd_write) else $error("pull-down write lost"); // RULE_04

  property p_open_drain;
    !st_reg.od[0] && !st_reg.dir[0] && st_reg.dout[0] |=> !pin_oe_o[0];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drives high"); // RULE_05

  property p_comparator_result_ro;
    wr && idx == `PPC_IDX_CMP |=> st_reg.cmp[`PPC_BIT_COMPARATOR_RESULT] == $past(st_reg.cmp[`PPC_BIT_COMPARATOR_RESULT]);
  endproperty
  a_comparator_result_ro: assert property (p_comparator_result_ro) else $error("result bit written"); // RULE_08

  property p_cos_unused;
    st_reg.cmp[`PPC_COS_HI:`PPC_COS_LO] == `PPC_COS_NONE |-> !comparator_on_o && !internal_ref_on_o;
  endproperty
  a_cos_unused: assert property (p_cos_unused) else $error("select 11 active"); // RULE_10

  property p_priority;
    st_reg.timer_irq_config[`PPC_BIT_TS] |=> shared_fn_o == PPC_FN_TIMER && !pin_oe_o[`PPC_SHARED_PIN];
  endproperty
  a_priority: assert property (p_priority) else $error("timer input lost priority"); // RULE_11

  property p_rise_count;
    st_reg.timer_irq_config[`PPC_BIT_TS] && !st_reg.timer_irq_config[`PPC_BIT_TE] && !wr && $rose(st_reg.s2[`PPC_SHARED_PIN])
      |=> timer_count_o == $past(timer_count_o) + 8'h01;
  endproperty
  a_rise_count: assert property (p_rise_count) else $error("rising edge not counted"); // RULE_14

  property p_no_tick;
    st_reg.timer_irq_config[`PPC_BIT_TS] && !wr && st_reg.s2[`PPC_SHARED_PIN] == st_reg.t5prev |=> $stable(timer_count_o);
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("count without edge"); // RULE_15

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_minus_hiz;
    st_reg.cmp[`PPC_BIT_INTERNAL_REF_ENABLE_N] && comparator_on_o |=> !pin_oe_o[`PPC_MINUS_PIN];
  endproperty
  a_minus_hiz: assert property (p_minus_hiz) else $error("minus input driven"); // RULE_06

  property p_minus_io;
    !st_reg.cmp[`PPC_BIT_INTERNAL_REF_ENABLE_N] && !st_reg.dir[`PPC_MINUS_PIN] && st_reg.od[`PPC_MINUS_PIN]
      |=> pin_oe_o[`PPC_MINUS_PIN];
  endproperty
  a_minus_io: assert property (p_minus_io) else $error("minus pin not plain output"); // RULE_06

  property p_ratio;
    wr && idx == `PPC_IDX_CMP |=> reference_ratio_o == $past(wb_dat_i[`PPC_RATIO_HI:`PPC_RATIO_LO]);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio write lost"); // RULE_07

  property p_cmp_pin;
    !st_reg.timer_irq_config[`PPC_BIT_TS] && st_reg.cmp[`PPC_COS_HI:`PPC_COS_LO] == `PPC_COS_PIN
      |=> pin_oe_o[`PPC_SHARED_PIN] && pin_out_o[`PPC_SHARED_PIN] == $past(st_reg.c2);
  endproperty
  a_cmp_pin: assert property (p_cmp_pin) else $error("comparator not on shared pin"); // RULE_10

  property p_cos_io;
    !st_reg.timer_irq_config[`PPC_BIT_TS] && st_reg.cmp[`PPC_COS_HI:`PPC_COS_LO] != `PPC_COS_PIN && !analog_input_five_i
      |=> shared_fn_o == PPC_FN_IO;
  endproperty
  a_cos_io: assert property (p_cos_io) else $error("shared pin not plain I/O"); // RULE_09

  property p_analog;
    !st_reg.timer_irq_config[`PPC_BIT_TS] && st_reg.cmp[`PPC_COS_HI:`PPC_COS_LO] != `PPC_COS_PIN && analog_input_five_i
      |=> shared_fn_o == PPC_FN_ANALOG && !pin_oe_o[`PPC_SHARED_PIN];
  endproperty
  a_analog: assert property (p_analog) else $error("analog input lost priority"); // RULE_11

  property p_fall_count;
    st_reg.timer_irq_config[`PPC_BIT_TS] && st_reg.timer_irq_config[`PPC_BIT_TE] && !wr && $fell(st_reg.s2[`PPC_SHARED_PIN])
      |=> timer_count_o == $past(timer_count_o) + 8'h01;
  endproperty
  a_fall_count: assert property (p_fall_count) else $error("falling edge not counted"); // RULE_14

  property p_tick;
    !st_reg.timer_irq_config[`PPC_BIT_TS] && instr_tick_i && !wr |=> timer_count_o == $past(timer_count_o) + 8'h01;
  endproperty
  a_tick: assert property (p_tick) else $error("instruction tick not counted"); // RULE_12

  c_cmp_pin: cover property (shared_fn_o == PPC_FN_CMP && pin_oe_o[`PPC_SHARED_PIN]);
  c_fall_count: cover property (st_reg.timer_irq_config[`PPC_BIT_TE] && st_reg.timer_irq_config[`PPC_BIT_TS] && $fell(st_reg.t5prev));
  c_analog: cover property (shared_fn_o == PPC_FN_ANALOG);
  c_write_ack: cover property (wr ##1 wb_ack_o);
  c_minus_analog: cover property (comparator_minus_input_o && !pin_oe_o[`PPC_MINUS_PIN]);

endmodule

// ### verification/ppc_pin_model.sv
// Far-side pad model: resolves each port pin from the block, an outside source and the pulls.
// Assumes one clock; a pin nobody drives or pulls shows the inverse of its last level.
`timescale 1ns/100ps
module ppc_pin_model (
  // Clock
  input wire logic clk_i,
  // Pad controls from the block
  input wire logic [6:0] pin_out_i,
  input wire logic [6:0] pin_oe_i,
  input wire logic [6:0] pu_en_i,
  input wire logic [6:0] pd_en_i,
  // Outside source
  input wire logic [6:0] ext_en_i,
  input wire logic [6:0] ext_val_i,
  // Resolved pins
  output logic [6:0] pin_in_o
);
  logic [6:0] last_reg;

  always_ff @(posedge clk_i) begin
    last_reg <= pin_in_o;
  end

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pin_oe_i[i]) begin
        pin_in_o[i] = pin_out_i[i];
      end else if (ext_en_i[i]) begin
        pin_in_o[i] = ext_val_i[i];
      end else if (pu_en_i[i]) begin
        pin_in_o[i] = 1'b1;
      end else if (pd_en_i[i]) begin
        pin_in_o[i] = 1'b0;
      end else begin
        pin_in_o[i] = ~last_reg[i];
      end
    end
  end
endmodule

// ### verification/port_pin_config_comparator_test.sv
// Self-checking bench: register accesses over Wishbone, pin, comparator and timer checks.
// Assumes ppc_top and the pad model; sel is fixed to byte 0, where every register lives.
`timescale 1ns/100ps
module port_pin_config_comparator_test
  import ppc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, ana = 1'b0, cmp_lvl = 1'b0;
  logic cmp_on, ref_on, minus_in, ack;
  logic [7:0] adr = 8'h00, tcount;
  logic [31:0] wdat = 32'h0, dat, rd;
  logic [6:0] pin_in, pout, poe, pu_en, pd_en, ext_en = 7'h00, ext_val = 7'h00;
  logic [3:0] ratio;
  ppc_fn_t fn;
  int failures = 0;
  int n_checks = 0;

  always #4 clk_i = ~clk_i;

  ppc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
    .pin_in_i(pin_in), .pin_out_o(pout), .pin_oe_o(poe), .pullup_en_o(pu_en), .pulldown_en_o(pd_en),
    .analog_input_five_i(ana), .instr_tick_i(tick), .shared_fn_o(fn), .timer_count_o(tcount),
    .comparator_result_i(cmp_lvl), .comparator_on_o(cmp_on), .internal_ref_on_o(ref_on),
    .reference_ratio_o(ratio), .comparator_minus_input_o(minus_in));

  ppc_pin_model u_pads (.clk_i(clk_i), .pin_out_i(pout), .pin_oe_i(poe), .pu_en_i(pu_en),
    .pd_en_i(pd_en), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_in_o(pin_in));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ack is sampled at the rising edge; the request stands until that edge, then drops.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    bit got;
    got = 1'b0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) begin
        got = 1'b1;
        rd = dat;
      end
    end
    if (!got) begin
      failures++;
      end_of_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(name, {24'h0, exp}, rd);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("timer_cfg", 8'h00, 8'h00);
    for (int i = 1; i < 5; i++) begin
      rdchk("pin_cfg", 8'(i * 4), 8'h7f);
    end
    rdchk("cmp_cfg", 8'h14, 8'h78);
    $display("test reset done");
    wb(1'b1, 8'h08, 8'h00);
    chk("pu_en", 32'h7f, {25'h0, pu_en});
    rdchk("pins_up", 8'h1c, 8'h7f);
    wb(1'b1, 8'h08, 8'hff);
    rdchk("pu_rb", 8'h08, 8'h7f);
    wb(1'b1, 8'h0c, 8'h00);
    chk("pd_en", 32'h7f, {25'h0, pd_en});
    rdchk("pins_dn", 8'h1c, 8'h00);
    wb(1'b1, 8'h0c, 8'hff);
    rdchk("pd_rb", 8'h0c, 8'h7f);
    wb(1'b1, 8'h10, 8'hff);
    rdchk("od_rb", 8'h10, 8'h7f);
    $display("test pulls done");
    wb(1'b1, 8'h1c, 8'h55);
    wb(1'b1, 8'h04, 8'h00);
    chk("oe_pp", 32'h7f, {25'h0, poe});
    chk("out_pp", 32'h55, {25'h0, pout});
    rdchk("pins_pp", 8'h1c, 8'h55);
    wb(1'b1, 8'h10, 8'h00);
    wb(1'b1, 8'h08, 8'h00);
    chk("oe_od", 32'h2a, {25'h0, poe});
    chk("out_od", 32'h00, {25'h0, pout});
    rdchk("pins_od", 8'h1c, 8'h55);
    wb(1'b1, 8'h10, 8'h7f);
    wb(1'b1, 8'h04, 8'h7f);
    wb(1'b1, 8'h08, 8'h7f);
    $display("test drive done");
    cmp_lvl <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, 8'h14, 8'h50 | 8'(s));
      chk("cmp_on", 32'(s == 1 || s == 2), {31'h0, cmp_on});
      chk("ref_on", 32'(s == 1 || s == 2), {31'h0, ref_on});
      chk("ratio", 32'ha, {28'h0, ratio});
      chk("fn", (s == 2) ? 32'(PPC_FN_CMP) : 32'(PPC_FN_IO), {30'h0, fn});
      rdchk("cmp_rb", 8'h14, 8'h54 | 8'(s));
      if (s == 2) begin
        chk("co_pin", 32'h3, {30'h0, poe[5], pout[5]});
      end
    end
    wb(1'b1, 8'h14, 8'hf9);
    chk("minus_ref_off", 32'h2, {30'h0, minus_in, ref_on});
    cmp_lvl <= 1'b0;
    wb(1'b1, 8'h14, 8'h7c);
    rdchk("cmp_ro", 8'h14, 8'h78);
    $display("test comparator done");
    ana <= 1'b1;
    wb(1'b1, 8'h14, 8'h78);
    chk("fn_an", 32'(PPC_FN_ANALOG), {30'h0, fn});
    wb(1'b1, 8'h14, 8'h7a);
    chk("fn_co", 32'(PPC_FN_CMP), {30'h0, fn});
    wb(1'b1, 8'h00, 8'h20);
    chk("fn_tm", 32'(PPC_FN_TIMER), {30'h0, fn});
    ana <= 1'b0;
    wb(1'b1, 8'h14, 8'h78);
    $display("test priority done");
    ext_en <= 7'h20;
    for (int te = 0; te < 2; te++) begin
      ext_val <= 7'h00;
      wb(1'b1, 8'h00, 8'h20 | 8'(te << 4));
      wb(1'b1, 8'h18, 8'h00);
      repeat (3) begin
        ext_val[5] <= ~ext_val[5];
        repeat (8) @(posedge clk_i);
      end
      chk("tcount", te ? 32'h1 : 32'h2, {24'h0, tcount});
      rdchk("tcount_rb", 8'h18, te ? 8'h01 : 8'h02);
    end
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h18, 8'h00);
    ext_val[5] <= ~ext_val[5];
    repeat (3) begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      @(posedge clk_i);
    end
    rdchk("tick_count", 8'h18, 8'h03);
    $display("test timer done");
    end_of_test();
  end
endmodule
